// ### adcam_mst.sv
// Partner: two-wire bus master model with byte-level tasks
`timescale 1ns/1ps
`default_nettype none
module adcam_mst (
  // Clock
  input wire logic clk,
  // Bus lines, data as open-drain pull-down request
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hp;
    repeat (16) @(posedge clk);
  endtask
  // Start or repeated start; clock stands high between frames
  task automatic start;
    sda_low <= 1'b0;
    hp();
    scl <= 1'b1;
    hp();
    sda_low <= 1'b1;
    hp();
    scl <= 1'b0;
    hp();
  endtask
  task automatic stop;
    sda_low <= 1'b1;
    hp();
    scl <= 1'b1;
    hp();
    sda_low <= 1'b0;
    hp();
  endtask
  // Data changes only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_low <= !b;
    hp();
    scl <= 1'b1;
    hp();
    r = sda;
    scl <= 1'b0;
    hp();
  endtask
  task automatic send(input logic [7:0] d, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, nack);
  endtask
  task automatic recv(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(!ack, r);
  endtask
endmodule
`default_nettype wire

// ### adcam_pkg.sv
// Package: constants, state types and carriers of the alert monitor
package adcam_pkg;
  localparam int RES_W = 12;
  // Register pointer values
  localparam logic [3:0] PTR_RESULT = 4'h0;
  localparam logic [3:0] PTR_STATUS = 4'h1;
  localparam logic [3:0] PTR_CONFIG = 4'h2;
  localparam logic [3:0] PTR_LIM_LO = 4'h3;
  localparam logic [3:0] PTR_LIM_HI = 4'h4;
  localparam logic [3:0] PTR_HYST = 4'h5;
  localparam logic [3:0] PTR_MIN = 4'h6;
  localparam logic [3:0] PTR_MAX = 4'h7;
  // Configuration, status and result field positions
  localparam int CFG_CYC_HI = 7;
  localparam int CFG_CYC_LO = 5;
  localparam int CFG_HOLD = 4;
  localparam int CFG_FLAG_EN = 3;
  localparam int CFG_PIN_EN = 2;
  localparam int CFG_POL = 0;
  localparam int STS_UNDER = 0;
  localparam int STS_OVER = 1;
  localparam int RES_ALERT_BIT = 7;
  // Reset values
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [11:0] LIM_HI_RST = 12'hFFF;
  localparam logic [11:0] LIM_LO_RST = 12'h000;
  localparam logic [11:0] HYST_RST = 12'h000;
  localparam logic [11:0] MIN_RST = 12'hFFF;
  localparam logic [11:0] MAX_RST = 12'h000;
  // Slave address
  localparam logic [6:0] FIXED_ADDR = 7'h54;
  localparam logic [2:0] ADDR_PREFIX = 3'h5;
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_FLOAT = 2'h1;
  localparam logic [1:0] STRAP_SUPPLY = 2'h2;
  localparam logic [4:0] HS_CODE_TOP = 5'h01;
  // Automatic conversion period, in converter clocks, for cycle code 1
  localparam logic [11:0] AUTO_BASE = 12'h020;

  typedef enum logic [3:0] {
    BUS_IDLE = 4'b0000,
    BUS_ADDR = 4'b0001,
    BUS_ACK_A = 4'b0010,
    BUS_PTR = 4'b0011,
    BUS_ACK_P = 4'b0100,
    BUS_WR = 4'b0101,
    BUS_ACK_W = 4'b0110,
    BUS_RD = 4'b0111,
    BUS_ACK_R = 4'b1000
  } adcam_bus_st_t;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    logic [1:0] lo_s1;
    logic [1:0] lo_s2;
    logic [1:0] hi_s1;
    logic [1:0] hi_s2;
    logic tog_s1;
    logic tog_s2;
    logic tog_d;
    adcam_bus_st_t st;
    logic [2:0] bitcnt;
    logic full;
    logic [7:0] sh;
    logic rw;
    logic nack;
    logic [3:0] ptr;
    logic low_half;
    logic [7:0] wbuf;
    logic sda_oe;
    logic [7:0] cfg;
    logic over;
    logic under;
    logic [11:0] result;
    logic [11:0] lim_hi;
    logic [11:0] lim_lo;
    logic [11:0] hyst;
    logic [11:0] vmin;
    logic [11:0] vmax;
    logic alert;
  } adcam_sys_t;

  typedef struct packed {
    logic [2:0] cyc_s1;
    logic [2:0] cyc_s2;
    logic [11:0] cnt;
    logic start;
    logic osc_en;
    logic [11:0] hold;
    logic tog;
  } adcam_conv_t;
endpackage

// ### adcam_top.sv
// Alert monitor: two-wire slave, limit checker and automatic conversion timer
`timescale 1ns/1ps
`default_nettype none
module adcam_top
  import adcam_pkg::*;
#(
  parameter bit HAS_STRAPS = 1'b1
) (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Two-wire bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Address straps, three-state codes from the pad decoders
  input wire logic [1:0] addr_strap_lo,
  input wire logic [1:0] addr_strap_hi,
  // Alert pin
  output logic alert_out,
  // Converter core, on its own clock
  input wire logic clk_conv,
  input wire logic conv_done,
  input wire logic [RES_W-1:0] conv_data,
  output logic conv_start,
  output logic osc_en
);

  adcam_sys_t q;
  adcam_sys_t next_q;
  adcam_conv_t c;
  adcam_conv_t next_c;

  function automatic logic [1:0] strap_field(input logic [1:0] code);
    case (code)
      STRAP_FLOAT: strap_field = 2'h0;
      STRAP_GND: strap_field = 2'h1;
      STRAP_SUPPLY: strap_field = 2'h2;
      default: strap_field = 2'h0;
    endcase
  endfunction

  function automatic logic [7:0] hi_byte(input logic [11:0] v);
    hi_byte = {4'h0, v[11:8]};
  endfunction

  logic [6:0] my_addr;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic new_res;
  logic any_alert;
  logic [7:0] tx_byte;
  logic [7:0] res_hi;
  logic [12:0] hi_band;
  logic [12:0] lo_band;

  // Address from straps, or fixed when the pads are absent
  assign my_addr = HAS_STRAPS ?
    {ADDR_PREFIX, strap_field(q.hi_s2), strap_field(q.lo_s2)} : FIXED_ADDR;

  assign scl_rise = q.scl_s2 & ~q.scl_d;
  assign scl_fall = ~q.scl_s2 & q.scl_d;
  assign start_seen = q.scl_s2 & q.scl_d & q.sda_d & ~q.sda_s2;
  assign stop_seen = q.scl_s2 & q.scl_d & ~q.sda_d & q.sda_s2;
  assign new_res = q.tog_s2 ^ q.tog_d;
  assign any_alert = q.over | q.under;
  // Widened by one bit so lim_lo plus hyst never wraps; lim_hi minus hyst still wraps when hyst exceeds lim_hi
  assign hi_band = {1'b0, q.lim_hi} - {1'b0, q.hyst};
  assign lo_band = {1'b0, q.lim_lo} + {1'b0, q.hyst};
  assign res_hi = {any_alert & q.cfg[CFG_FLAG_EN], 3'h0, q.result[11:8]};

  // Byte the pointer selects; one-byte registers repeat on every read
  always_comb begin
    case (q.ptr)
      PTR_RESULT: tx_byte = q.low_half ? q.result[7:0] : res_hi;
      PTR_STATUS: tx_byte = {6'h00, q.over, q.under};
      PTR_CONFIG: tx_byte = q.cfg;
      PTR_LIM_LO: tx_byte = q.low_half ? q.lim_lo[7:0] : hi_byte(q.lim_lo);
      PTR_LIM_HI: tx_byte = q.low_half ? q.lim_hi[7:0] : hi_byte(q.lim_hi);
      PTR_HYST: tx_byte = q.low_half ? q.hyst[7:0] : hi_byte(q.hyst);
      PTR_MIN: tx_byte = q.low_half ? q.vmin[7:0] : hi_byte(q.vmin);
      PTR_MAX: tx_byte = q.low_half ? q.vmax[7:0] : hi_byte(q.vmax);
      default: tx_byte = 8'h00;
    endcase
  end

  // System domain: bus slave, register file, alert logic
  always_comb begin
    next_q = q;
    // Pins and straps pass two flops before use
    next_q.scl_s1 = scl_in;
    next_q.scl_s2 = q.scl_s1;
    next_q.scl_d = q.scl_s2;
    next_q.sda_s1 = sda_in;
    next_q.sda_s2 = q.sda_s1;
    next_q.sda_d = q.sda_s2;
    next_q.lo_s1 = addr_strap_lo;
    next_q.lo_s2 = q.lo_s1;
    next_q.hi_s1 = addr_strap_hi;
    next_q.hi_s2 = q.hi_s1;
    next_q.tog_s1 = c.tog;
    next_q.tog_s2 = q.tog_s1;
    next_q.tog_d = q.tog_s2;

    // Count clock rises; full marks a complete byte
    if (scl_rise && q.st != BUS_IDLE) begin
      next_q.sh = (q.st == BUS_RD) ? q.sh : {q.sh[6:0], q.sda_s2};
      next_q.bitcnt = q.bitcnt + 3'h1;
      next_q.full = (q.bitcnt == 3'h7);
      if (q.st == BUS_ACK_R) begin
        next_q.nack = q.sda_s2;
      end
    end

    if (scl_fall) begin
      case (q.st)
        BUS_ADDR: begin
          if (q.full) begin
            next_q.full = 1'b0;
            // Master code and foreign addresses get no acknowledge
            if (q.sh[7:1] == my_addr && q.sh[7:3] != HS_CODE_TOP) begin
              next_q.sda_oe = 1'b1;
              next_q.rw = q.sh[0];
              next_q.st = BUS_ACK_A;
            end else begin
              next_q.st = BUS_IDLE;
            end
          end
        end
        BUS_ACK_A: begin
          next_q.bitcnt = 3'h0;
          next_q.low_half = 1'b0;
          if (q.rw) begin
            next_q.sh = tx_byte;
            next_q.sda_oe = ~tx_byte[7];
            next_q.st = BUS_RD;
          end else begin
            next_q.sda_oe = 1'b0;
            next_q.st = BUS_PTR;
          end
        end
        BUS_PTR: begin
          if (q.full) begin
            next_q.full = 1'b0;
            next_q.ptr = q.sh[3:0];
            next_q.sda_oe = 1'b1;
            next_q.st = BUS_ACK_P;
          end
        end
        BUS_WR: begin
          if (q.full) begin
            next_q.full = 1'b0;
            next_q.sda_oe = 1'b1;
            next_q.st = BUS_ACK_W;
            next_q.low_half = ~q.low_half;
            case (q.ptr)
              PTR_CONFIG: begin
                next_q.cfg = q.sh;
                next_q.low_half = 1'b0;
              end
              PTR_STATUS: begin
                next_q.over = q.over & ~q.sh[STS_OVER];
                next_q.under = q.under & ~q.sh[STS_UNDER];
                next_q.low_half = 1'b0;
              end
              PTR_LIM_LO: if (q.low_half) next_q.lim_lo = {q.wbuf[3:0], q.sh};
              PTR_LIM_HI: if (q.low_half) next_q.lim_hi = {q.wbuf[3:0], q.sh};
              PTR_HYST: if (q.low_half) next_q.hyst = {q.wbuf[3:0], q.sh};
              PTR_MIN: if (q.low_half) next_q.vmin = {q.wbuf[3:0], q.sh};
              PTR_MAX: if (q.low_half) next_q.vmax = {q.wbuf[3:0], q.sh};
              default: next_q.low_half = 1'b0;
            endcase
            next_q.wbuf = q.sh;
          end
        end
        BUS_ACK_P, BUS_ACK_W: begin
          next_q.sda_oe = 1'b0;
          next_q.bitcnt = 3'h0;
          next_q.st = BUS_WR;
          if (q.st == BUS_ACK_P) begin
            next_q.low_half = 1'b0;
          end
        end
        BUS_RD: begin
          if (q.full) begin
            next_q.full = 1'b0;
            next_q.sda_oe = 1'b0;
            next_q.st = BUS_ACK_R;
            // Step the half here so the next byte is fetched from the new half
            if (q.ptr == PTR_STATUS || q.ptr == PTR_CONFIG || q.ptr > PTR_MAX) begin
              next_q.low_half = 1'b0;
            end else begin
              next_q.low_half = ~q.low_half;
            end
          end else begin
            next_q.sh = {q.sh[6:0], 1'b0};
            next_q.sda_oe = ~q.sh[6];
          end
        end
        BUS_ACK_R: begin
          next_q.bitcnt = 3'h0;
          next_q.full = 1'b0;
          if (q.nack) begin
            next_q.st = BUS_IDLE;
          end else begin
            next_q.sh = tx_byte;
            next_q.sda_oe = ~tx_byte[7];
            next_q.st = BUS_RD;
          end
        end
        default: next_q.sda_oe = 1'b0;
      endcase
    end

    // Start and stop override any bit in flight
    if (start_seen) begin
      next_q.st = BUS_ADDR;
      next_q.bitcnt = 3'h0;
      // Every frame opens on the upper byte
      next_q.low_half = 1'b0;
      next_q.full = 1'b0;
      next_q.sda_oe = 1'b0;
      next_q.nack = 1'b0;
    end else if (stop_seen) begin
      next_q.st = BUS_IDLE;
      next_q.sda_oe = 1'b0;
    end

    // Conversion result arrives; set is applied after any write clear
    if (new_res) begin
      next_q.result = c.hold;
      if (c.hold > q.lim_hi) begin
        next_q.over = 1'b1;
      end else if (!q.cfg[CFG_HOLD] && {1'b0, c.hold} < hi_band) begin
        next_q.over = 1'b0;
      end
      if (c.hold < q.lim_lo) begin
        next_q.under = 1'b1;
      end else if (!q.cfg[CFG_HOLD] && {1'b0, c.hold} > lo_band) begin
        next_q.under = 1'b0;
      end
      if (q.cfg[CFG_CYC_HI:CFG_CYC_LO] != 3'h0) begin
        if (c.hold < q.vmin) next_q.vmin = c.hold;
        if (c.hold > q.vmax) next_q.vmax = c.hold;
      end
    end

    // Pin follows the registered flags one cycle later
    next_q.alert = q.cfg[CFG_POL] ~^ (q.cfg[CFG_PIN_EN] & any_alert);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.scl_s1 <= 1'b1;
      q.scl_s2 <= 1'b1;
      q.scl_d <= 1'b1;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
      q.sda_d <= 1'b1;
      q.st <= BUS_IDLE;
      q.cfg <= CFG_RST;
      q.lim_hi <= LIM_HI_RST;
      q.lim_lo <= LIM_LO_RST;
      q.hyst <= HYST_RST;
      q.vmin <= MIN_RST;
      q.vmax <= MAX_RST;
      q.alert <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // Converter domain: cycle timer and result capture
  always_comb begin
    next_c = c;
    // Cycle field is quasi-static; two flops suffice
    next_c.cyc_s1 = q.cfg[CFG_CYC_HI:CFG_CYC_LO];
    next_c.cyc_s2 = c.cyc_s1;
    next_c.osc_en = (c.cyc_s2 != 3'h0);
    next_c.start = 1'b0;
    if (c.cyc_s2 == 3'h0) begin
      next_c.cnt = 12'h000;
    end else if (c.cnt == 12'h000) begin
      next_c.start = 1'b1;
      next_c.cnt = 12'(AUTO_BASE << (c.cyc_s2 - 3'h1)) - 12'h001;
    end else begin
      next_c.cnt = c.cnt - 12'h001;
    end
    // Held word stays still long after the toggle crosses
    if (conv_done) begin
      next_c.hold = conv_data;
      next_c.tog = ~c.tog;
    end
  end

  always_ff @(posedge clk_conv or negedge rst_b) begin
    if (!rst_b) begin
      c <= '0;
    end else begin
      c <= next_c;
    end
  end

  assign sda_out = 1'b0 & q.sda_d;
  assign sda_oe = q.sda_oe;
  assign alert_out = q.alert;
  assign conv_start = c.start;
  assign osc_en = c.osc_en;

endmodule
`default_nettype wire

// ### adcam_top_bench.sv
// Testbench: bus master, converter stand-in and scenarios for the alert monitor
`timescale 1ns/1ps
`default_nettype none
module adcam_top_bench
  import adcam_pkg::*;
;
  localparam logic [6:0] DEV_ADDR = 7'h50;
  logic clk_sys, rst_b, clk_conv, conv_done, man_req;
  logic [RES_W-1:0] conv_data;
  logic [1:0] addr_strap_lo, addr_strap_hi;
  logic scl, m_low, sda, sda_out, sda_oe, alert_out, conv_start, osc_en;
  int errors, n_compared;
  // Pull-up: either party pulling low wins
  assign sda = !(m_low || (sda_oe && !sda_out));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    clk_conv = 1'b0;
    #7.3;
    forever #32 clk_conv = ~clk_conv;
  end
  adcam_top #(.HAS_STRAPS(1'b1)) i_adcam_top (.clk_sys(clk_sys), .rst_b(rst_b), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_lo(addr_strap_lo),
    .addr_strap_hi(addr_strap_hi), .alert_out(alert_out), .clk_conv(clk_conv),
    .conv_done(conv_done), .conv_data(conv_data), .conv_start(conv_start), .osc_en(osc_en));
  adcam_mst i_adcam_mst (.clk(clk_sys), .scl(scl), .sda_low(m_low), .sda(sda));
  // Converter stand-in answers each start one cycle later
  always @(posedge clk_conv) conv_done <= conv_start || man_req;
  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic final_report;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  function automatic logic [1:0] smap(input logic [1:0] c);
    return (c == 2'h1) ? 2'h0 : (c == 2'h0) ? 2'h1 : 2'h2;
  endfunction
  task automatic wr(input logic [3:0] p, input logic [15:0] v, input bit two);
    logic n;
    i_adcam_mst.start();
    i_adcam_mst.send({DEV_ADDR, 1'b0}, n);
    i_adcam_mst.send({4'h0, p}, n);
    if (two) i_adcam_mst.send(v[15:8], n);
    i_adcam_mst.send(v[7:0], n);
    i_adcam_mst.stop();
  endtask
  task automatic rchk(input logic [3:0] p, input bit two, input logic [15:0] exp);
    logic n;
    logic [15:0] v;
    v = 16'h0000;
    i_adcam_mst.start();
    i_adcam_mst.send({DEV_ADDR, 1'b0}, n);
    i_adcam_mst.send({4'h0, p}, n);
    i_adcam_mst.start();
    i_adcam_mst.send({DEV_ADDR, 1'b1}, n);
    if (two) i_adcam_mst.recv(1'b1, v[15:8]);
    i_adcam_mst.recv(1'b0, v[7:0]);
    i_adcam_mst.stop();
    chk("register read", v, exp);
  endtask
  task automatic conv(input logic [11:0] v);
    @(posedge clk_conv);
    conv_data <= v;
    man_req <= 1'b1;
    @(posedge clk_conv);
    man_req <= 1'b0;
    repeat (40) @(posedge clk_sys);
  endtask
  task automatic wait_starts(input int n);
    int k;
    k = 0;
    for (int t = 0; t < 400 && k < n; t++) begin
      @(negedge clk_conv);
      if (conv_start === 1'b1) k++;
    end
    if (k < n) begin
      errors++;
      $display("BAD conversion starts expected %0d seen %0d", n, k);
      final_report();
    end
  endtask
  task automatic t_addr;
    logic n;
    for (int h = 0; h < 3; h++) begin
      for (int l = 0; l < 3; l++) begin
        addr_strap_hi <= 2'(h);
        addr_strap_lo <= 2'(l);
        repeat (8) @(posedge clk_sys);
        i_adcam_mst.start();
        i_adcam_mst.send({3'h5, smap(2'(h)), smap(2'(l)), 1'b0}, n);
        chk("strap address ack", 16'(n), 16'h0000);
        i_adcam_mst.stop();
      end
    end
    addr_strap_hi <= 2'h1;
    addr_strap_lo <= 2'h1;
    repeat (8) @(posedge clk_sys);
    i_adcam_mst.start();
    i_adcam_mst.send({7'h51, 1'b0}, n);
    chk("foreign address nack", 16'(n), 16'h0001);
    i_adcam_mst.start();
    i_adcam_mst.send(8'h09, n);
    chk("master code nack", 16'(n), 16'h0001);
    i_adcam_mst.start();
    i_adcam_mst.send({DEV_ADDR, 1'b0}, n);
    chk("address after restart", 16'(n), 16'h0000);
    i_adcam_mst.stop();
  endtask
  task automatic t_lim;
    wr(PTR_LIM_HI, 16'h0800, 1);
    wr(PTR_LIM_LO, 16'h0100, 1);
    wr(PTR_HYST, 16'h0010, 1);
    wr(PTR_CONFIG, 16'h000C, 0);
    chk("alert idle", 16'(alert_out), 16'h0001);
    conv(12'h900);
    rchk(PTR_STATUS, 0, 16'h0002);
    chk("alert low active", 16'(alert_out), 16'h0000);
    rchk(PTR_RESULT, 1, 16'h8900);
    conv(12'h7F5);
    rchk(PTR_STATUS, 0, 16'h0002);
    conv(12'h7E0);
    rchk(PTR_STATUS, 0, 16'h0000);
    chk("alert released", 16'(alert_out), 16'h0001);
    conv(12'h0FF);
    rchk(PTR_STATUS, 0, 16'h0001);
    conv(12'h110);
    rchk(PTR_STATUS, 0, 16'h0001);
    conv(12'h111);
    rchk(PTR_STATUS, 0, 16'h0000);
  endtask
  task automatic t_hold;
    wr(PTR_CONFIG, 16'h001D, 0);
    chk("alert high idle", 16'(alert_out), 16'h0000);
    conv(12'h900);
    chk("alert high active", 16'(alert_out), 16'h0001);
    conv(12'h400);
    rchk(PTR_STATUS, 0, 16'h0002);
    wr(PTR_STATUS, 16'h0002, 0);
    rchk(PTR_STATUS, 0, 16'h0000);
    chk("alert cleared", 16'(alert_out), 16'h0000);
    conv(12'h900);
    wr(PTR_STATUS, 16'h0002, 0);
    conv(12'h900);
    rchk(PTR_STATUS, 0, 16'h0002);
    chk("alert again", 16'(alert_out), 16'h0001);
    wr(PTR_STATUS, 16'h0003, 0);
  endtask
  task automatic t_auto;
    @(posedge clk_conv);
    conv_data <= 12'h300;
    wr(PTR_CONFIG, 16'h0020, 0);
    wait_starts(3);
    @(posedge clk_conv);
    conv_data <= 12'h700;
    wait_starts(3);
    @(posedge clk_conv);
    conv_data <= 12'h100;
    wait_starts(3);
    repeat (40) @(posedge clk_sys);
    chk("oscillator on", 16'(osc_en), 16'h0001);
    chk("alert pin off", 16'(alert_out), 16'h0001);
    rchk(PTR_MIN, 1, 16'h0100);
    rchk(PTR_MAX, 1, 16'h0700);
    rchk(PTR_RESULT, 1, 16'h0100);
    wr(PTR_CONFIG, 16'h0000, 0);
    repeat (20) @(posedge clk_conv);
    chk("oscillator off", 16'(osc_en), 16'h0000);
  endtask
  initial begin
    errors = 0;
    n_compared = 0;
    rst_b = 1'b0;
    man_req = 1'b0;
    conv_data = 12'h000;
    addr_strap_lo = 2'h1;
    addr_strap_hi = 2'h1;
    repeat (16) @(posedge clk_sys);
    repeat (2) @(posedge clk_conv);
    @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk("alert after reset", 16'(alert_out), 16'h0001);
    t_addr();
    t_lim();
    t_hold();
    t_auto();
    final_report();
  end
endmodule
bind adcam_top adcam_top_chk i_adcam_top_chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .clk_conv(clk_conv), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .conv_start(conv_start), .osc_en(osc_en));
`default_nettype wire

// ### adcam_top_chk.sv
// Checker: port-level properties of the alert monitor
`timescale 1ns/1ps
`default_nettype none
module adcam_top_chk (
  // Clocks and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_conv,
  // Bus
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Converter
  input wire logic conv_start,
  input wire logic osc_en
);
  property p_od_low;
    @(posedge clk_sys) disable iff (!rst_b) sda_oe |-> !sda_out;
  endproperty
  a_od_low: assert property (p_od_low) else $error("data pin driven high");
  // Drive changes only in the clock-low phase, never under a high clock
  property p_oe_scl_low;
    @(posedge clk_sys) disable iff (!rst_b) $changed(sda_oe) |-> !scl_in;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data drive moved, clock high");
  property p_oe_hold_on;
    @(posedge clk_sys) disable iff (!rst_b) $rose(sda_oe) |=> sda_oe [*8];
  endproperty
  a_oe_hold_on: assert property (p_oe_hold_on) else $error("pull-down too short");
  property p_oe_hold_off;
    @(posedge clk_sys) disable iff (!rst_b) $fell(sda_oe) |=> !sda_oe [*4];
  endproperty
  a_oe_hold_off: assert property (p_oe_hold_off) else $error("release too short");
  property p_start_pulse;
    @(posedge clk_conv) disable iff (!rst_b) conv_start |=> !conv_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
  property p_start_gap;
    @(posedge clk_conv) disable iff (!rst_b) conv_start |-> ##2 !conv_start [*8];
  endproperty
  a_start_gap: assert property (p_start_gap) else $error("starts too close");
  property p_start_auto;
    @(posedge clk_conv) disable iff (!rst_b) conv_start |-> ##[0:1] osc_en;
  endproperty
  a_start_auto: assert property (p_start_auto) else $error("start outside automatic mode");
  property p_idle_quiet;
    @(posedge clk_conv) disable iff (!rst_b) !osc_en ##1 !osc_en |-> !conv_start;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("start while idle");
endmodule
`default_nettype wire

// ### adcam_top_note_unused.sv
// Intentionally minimal: reserved for future split, holds no logic
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire
